/* design/vlqm_consts.svh */
`ifndef VLQM_CONSTS_SVH
`define VLQM_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses on the register port)
`define VLQM_ADDR_QCTRL    16'h0390
`define VLQM_ADDR_ENTRY0   16'h0400
`define VLQM_ADDR_ENTRY1   16'h0404
`define VLQM_ADDR_VIDX     16'h040C
`define VLQM_ADDR_ACTL     16'h040E

// ==========================================================================
// Reset values
`define VLQM_QCTRL_RST     8'h82
`define VLQM_QMAP_RST      2'h2
`define VLQM_DISCARD_RST   1'h1

// ==========================================================================
// Field positions
`define VLQM_QMAP_HI       7
`define VLQM_QMAP_LO       6
`define VLQM_QRESV_HI      5
`define VLQM_QRESV_LO      2
`define VLQM_DISCARD_BIT   1
`define VLQM_QBIT0_BIT     0
`define VLQM_VALID_BIT     31
`define VLQM_FO_BIT        27
`define VLQM_PRIO_HI       26
`define VLQM_PRIO_LO       24
`define VLQM_MSTI_HI       14
`define VLQM_MSTI_LO       12
`define VLQM_FID_HI        6
`define VLQM_FID_LO        0
`define VLQM_UNTAG_LO_HI   3
`define VLQM_UNTAG_P5_BIT  6
`define VLQM_IDX_HI        11
`define VLQM_START_BIT     7
`define VLQM_ACT_HI        1

`endif

/* design/vlqm_pkg.sv */
package vlqm_pkg;

  // ========================================================================
  // Table actions and two-queue map codes
  typedef enum logic [1:0] {
    VLQM_ACT_NOP   = 2'b00,
    VLQM_ACT_WRITE = 2'b01,
    VLQM_ACT_READ  = 2'b10,
    VLQM_ACT_CLEAR = 2'b11
  } vlqm_action_t;

  typedef enum logic [1:0] {
    VLQM_QMAP_P3     = 2'b00,
    VLQM_QMAP_UNUSED = 2'b01,
    VLQM_QMAP_P23    = 2'b10,
    VLQM_QMAP_P123   = 2'b11
  } vlqm_qmap_t;

  typedef enum logic {
    VLQM_ST_IDLE = 1'b0,
    VLQM_ST_WAIT = 1'b1
  } vlqm_state_t;

  // ========================================================================
  // One VLAN table entry; untag[4] is port 5, untag[3:0] ports 4..1
  typedef struct packed {
    logic       valid;
    logic       fwdOpt;
    logic [2:0] prio;
    logic [2:0] msti;
    logic [6:0] filter_identifier;
    logic [4:0] untag;
  } vlqm_entry_t;

  // Request to the table memory and its answer
  typedef struct packed {
    logic         req;
    vlqm_action_t action;
    logic [11:0]  index;
    vlqm_entry_t  entry;
  } vlqm_tbl_req_t;

  typedef struct packed {
    logic        done;
    vlqm_entry_t entry;
  } vlqm_tbl_rsp_t;

  // ========================================================================
  // Per-frame forwarding question and answer
  typedef struct packed {
    logic       valid;
    logic [1:0] prio;
    logic       entryFwdOpt;
    logic [4:0] entryPorts;
    logic [4:0] otherPorts;
    logic [4:0] memberPorts;
    logic       mirrorActive;
    logic       mirrorToOther;
  } vlqm_frame_t;

  typedef struct packed {
    logic       valid;
    logic       highQueue;
    logic [4:0] ports;
    logic       drop;
  } vlqm_verdict_t;

endpackage

/* design/vlqm_fwd_filter.sv */
`timescale 1ns/100ps

module vlqm_fwd_filter (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // Settings from the register bank
  input  wire vlqm_pkg::vlqm_qmap_t mapCode,
  input  wire logic                discardEn,
  // Frame question and registered answer
  input  wire vlqm_pkg::vlqm_frame_t frameIn,
  output vlqm_pkg::vlqm_verdict_t   verdictOut
);
  import vlqm_pkg::*;

  // ========================================================================
  // Helpers
  // Code 01 is unused; it falls back to the reset mapping
  function automatic logic mapHigh(input vlqm_qmap_t code,
                                   input logic [1:0] prio);
    case (code)
      VLQM_QMAP_P3:   mapHigh = (prio == 2'h3);
      VLQM_QMAP_P123: mapHigh = (prio != 2'h0);
      default:        mapHigh = prio[1];
    endcase
  endfunction

  function automatic logic oneDest(input logic [4:0] p);
    oneDest = (p != 5'h00) && ((p & (p - 5'h01)) == 5'h00);
  endfunction

  // ========================================================================
  // Decision
  logic [4:0]    basePorts;
  logic          single;
  vlqm_verdict_t verdictNext;

  // Port source, queue choice and membership filtering
  always_comb begin
    basePorts = frameIn.entryFwdOpt ? frameIn.entryPorts
                                    : frameIn.otherPorts;
    single                = oneDest(basePorts);
    verdictNext.valid     = frameIn.valid;
    verdictNext.highQueue = mapHigh(mapCode, frameIn.prio);
    verdictNext.drop      = 1'b0;
    if (discardEn || !single) begin
      verdictNext.ports = basePorts & frameIn.memberPorts;
    end else begin
      // Unconfined single target, but a mirrored copy is not allowed
      verdictNext.drop  = frameIn.mirrorActive
                          && frameIn.mirrorToOther;
      verdictNext.ports = verdictNext.drop ? 5'h00 : basePorts;
    end
  end

  // Answer is registered so the datapath sees a clean flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      verdictOut <= '0;
    end else begin
      verdictOut <= verdictNext;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_QMAP_ONLY3: assert property (
    frameIn.valid && mapCode == VLQM_QMAP_P3
    |=> verdictOut.highQueue == ($past(frameIn.prio) == 2'h3))
    else $error("code 00 queue choice wrong");
  AST_QMAP_1TO3: assert property (
    frameIn.valid && mapCode == VLQM_QMAP_P123
    |=> verdictOut.highQueue == ($past(frameIn.prio) != 2'h0))
    else $error("code 11 queue choice wrong");
  AST_QMAP_2TO3: assert property (
    frameIn.valid && mapCode == VLQM_QMAP_P23
    |=> verdictOut.highQueue == $past(frameIn.prio[1]))
    else $error("code 10 queue choice wrong");
  AST_MEMBER_CONFINE: assert property (
    frameIn.valid && discardEn
    |=> (verdictOut.ports & ~$past(frameIn.memberPorts)) == 5'h00)
    else $error("port outside membership with discard set");
  AST_SINGLE_FREE: assert property (
    frameIn.valid && !discardEn && single && !frameIn.mirrorActive
    |=> verdictOut.ports == $past(basePorts) && !verdictOut.drop)
    else $error("single-destination frame was limited");
  AST_MIRROR_DROP: assert property (
    frameIn.valid && !discardEn && single && frameIn.mirrorActive
    && frameIn.mirrorToOther
    |=> verdictOut.drop && verdictOut.ports == 5'h00)
    else $error("mirrored single-destination frame not dropped");
  AST_FO_TABLE_MAP: assert property (
    frameIn.valid && frameIn.entryFwdOpt
    |=> (verdictOut.ports & ~$past(frameIn.entryPorts)) == 5'h00)
    else $error("port outside entry map with option set");
  AST_FO_OTHER_MAP: assert property (
    frameIn.valid && !frameIn.entryFwdOpt
    |=> (verdictOut.ports & ~$past(frameIn.otherPorts)) == 5'h00)
    else $error("port outside other map with option clear");

endmodule

/* design/vlqm_regs.sv */
`timescale 1ns/100ps
`include "vlqm_consts.svh"

module vlqm_regs (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // Register port
  input  wire logic [15:0]           regAddr,
  input  wire logic [31:0]           regWrData,
  input  wire logic                  regWrStb,
  input  wire logic                  regRdStb,
  output logic [31:0]                regRdData,
  // Table memory port
  output vlqm_pkg::vlqm_tbl_req_t    tblReq,
  input  wire vlqm_pkg::vlqm_tbl_rsp_t tblRsp,
  output logic                       tableBusy,
  // Frame forwarding port
  input  wire vlqm_pkg::vlqm_frame_t frameIn,
  output vlqm_pkg::vlqm_verdict_t    verdictOut
);
  import vlqm_pkg::*;

  // ========================================================================
  // Word packing, shared by the read path and the checks
  function automatic logic [31:0] packEntry0(input vlqm_entry_t e);
    packEntry0                                 = 32'h0000_0000;
    packEntry0[`VLQM_VALID_BIT]                = e.valid;
    packEntry0[`VLQM_FO_BIT]                   = e.fwdOpt;
    packEntry0[`VLQM_PRIO_HI:`VLQM_PRIO_LO]    = e.prio;
    packEntry0[`VLQM_MSTI_HI:`VLQM_MSTI_LO]    = e.msti;
    packEntry0[`VLQM_FID_HI:`VLQM_FID_LO]      = e.filter_identifier;
  endfunction

  function automatic logic [31:0] packEntry1(input vlqm_entry_t e);
    packEntry1                                 = 32'h0000_0000;
    packEntry1[`VLQM_UNTAG_P5_BIT]             = e.untag[4];
    packEntry1[`VLQM_UNTAG_LO_HI:0]            = e.untag[3:0];
  endfunction

  // ========================================================================
  // Registers and decode
  vlqm_qmap_t    qmapReg;
  logic [3:0]    qResvReg;
  logic          discardReg;
  logic          qBit0Reg;
  vlqm_entry_t   entryReg;
  logic [11:0]   idxReg;
  vlqm_action_t  actionReg;
  vlqm_state_t   stateReg;
  logic          reqReg;
  logic [31:0]   rdDataReg;
  logic [31:0]   rdDataNext;
  logic [31:0]   entry0Word;
  logic [31:0]   entry1Word;
  logic [7:0]    qctrlWord;
  logic          busy;
  logic          wrQctrl;
  logic          wrEntry0;
  logic          wrEntry1;
  logic          wrVidx;
  logic          wrActl;
  logic          startHit;

  // Address decode; staging writes are held off while an action runs
  assign busy     = (stateReg == VLQM_ST_WAIT);
  assign wrQctrl  = regWrStb && (regAddr == `VLQM_ADDR_QCTRL);
  assign wrEntry0 = regWrStb && (regAddr == `VLQM_ADDR_ENTRY0) && !busy;
  assign wrEntry1 = regWrStb && (regAddr == `VLQM_ADDR_ENTRY1) && !busy;
  assign wrVidx   = regWrStb && (regAddr == `VLQM_ADDR_VIDX) && !busy;
  assign wrActl   = regWrStb && (regAddr == `VLQM_ADDR_ACTL) && !busy;
  assign startHit = wrActl && regWrData[`VLQM_START_BIT]
                    && (regWrData[`VLQM_ACT_HI:0] != VLQM_ACT_NOP);

  assign entry0Word = packEntry0(entryReg);
  assign entry1Word = packEntry1(entryReg);
  assign qctrlWord  = {qmapReg, qResvReg, discardReg, qBit0Reg};
  assign tableBusy  = busy;

  // ========================================================================
  // Queue management control word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      qmapReg    <= vlqm_qmap_t'(`VLQM_QMAP_RST);
      qResvReg   <= 4'h0;
      discardReg <= `VLQM_DISCARD_RST;
      qBit0Reg   <= 1'b0;
    end else if (wrQctrl) begin
      // Bits 31:8 are not stored at all
      qmapReg    <= vlqm_qmap_t'(regWrData[`VLQM_QMAP_HI:`VLQM_QMAP_LO]);
      qResvReg   <= regWrData[`VLQM_QRESV_HI:`VLQM_QRESV_LO];
      discardReg <= regWrData[`VLQM_DISCARD_BIT];
      qBit0Reg   <= regWrData[`VLQM_QBIT0_BIT];
    end
  end

  // ========================================================================
  // Entry staging: loaded by software or by a finished table read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      entryReg <= '0;
    end else if (busy && tblRsp.done && actionReg == VLQM_ACT_READ) begin
      entryReg <= tblRsp.entry;
    end else if (wrEntry0) begin
      entryReg.valid  <= regWrData[`VLQM_VALID_BIT];
      entryReg.fwdOpt <= regWrData[`VLQM_FO_BIT];
      entryReg.prio   <= regWrData[`VLQM_PRIO_HI:`VLQM_PRIO_LO];
      entryReg.msti   <= regWrData[`VLQM_MSTI_HI:`VLQM_MSTI_LO];
      entryReg.filter_identifier    <= regWrData[`VLQM_FID_HI:`VLQM_FID_LO];
    end else if (wrEntry1) begin
      entryReg.untag  <= {regWrData[`VLQM_UNTAG_P5_BIT],
                          regWrData[`VLQM_UNTAG_LO_HI:0]};
    end
  end

  // ========================================================================
  // Index and action fields
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idxReg    <= 12'h000;
      actionReg <= VLQM_ACT_NOP;
    end else begin
      if (wrVidx) begin
        idxReg <= regWrData[`VLQM_IDX_HI:0];
      end
      if (wrActl) begin
        actionReg <= vlqm_action_t'(regWrData[`VLQM_ACT_HI:0]);
      end
    end
  end

  // ========================================================================
  // Action sequencer: start is the busy state, so it clears on done.
  // A start with the no-operation action is ignored and issues no request.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= VLQM_ST_IDLE;
      reqReg   <= 1'b0;
    end else begin
      reqReg <= 1'b0;
      case (stateReg)
        VLQM_ST_IDLE: begin
          if (startHit) begin
            stateReg <= VLQM_ST_WAIT;
            reqReg   <= 1'b1;
          end
        end
        VLQM_ST_WAIT: begin
          if (tblRsp.done) begin
            stateReg <= VLQM_ST_IDLE;
          end
        end
        default: begin
          stateReg <= VLQM_ST_IDLE;
        end
      endcase
    end
  end

  // Request fields stay stable from the pulse until done;
  // they come straight from flops, so the table sees no glitches
  always_comb begin
    tblReq.req    = reqReg;
    tblReq.action = actionReg;
    tblReq.index  = idxReg;
    tblReq.entry  = entryReg;
  end

  // ========================================================================
  // Read path: data stands only in the cycle after the strobe
  always_comb begin
    rdDataNext = 32'h0000_0000;
    case (regAddr)
      `VLQM_ADDR_QCTRL:  rdDataNext[7:0]  = qctrlWord;
      `VLQM_ADDR_ENTRY0: rdDataNext       = entry0Word;
      `VLQM_ADDR_ENTRY1: rdDataNext       = entry1Word;
      `VLQM_ADDR_VIDX:   rdDataNext[11:0] = idxReg;
      `VLQM_ADDR_ACTL:   rdDataNext[7:0]  = {busy, 5'h00, actionReg};
      default:           rdDataNext       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdDataReg <= 32'h0000_0000;
    end else begin
      rdDataReg <= regRdStb ? rdDataNext : 32'h0000_0000;
    end
  end

  assign regRdData = rdDataReg;

  // ========================================================================
  // Forwarding decision
  vlqm_fwd_filter uFwd (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .mapCode    (qmapReg),
    .discardEn  (discardReg),
    .frameIn    (frameIn),
    .verdictOut (verdictOut)
  );

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Start is taken only when idle, so a start and a done never race
  sequence seqStart;
    startHit && !busy;
  endsequence

  sequence seqRunning;
    tblReq.req && busy ##1 !tblReq.req [*1];
  endsequence

  AST_START_ISSUES: assert property (
    seqStart |=> seqRunning)
    else $error("start did not issue a single request pulse");
  AST_START_CLEARS: assert property (
    busy && tblRsp.done |=> !busy && !tblReq.req)
    else $error("start bit did not clear on done");
  AST_NOP_IGNORED: assert property (
    !busy && wrActl && regWrData[1:0] == 2'b00 |=> !busy)
    else $error("no-operation action started the table");
  AST_VALID_BIT: assert property (
    wrEntry0 |=> entry0Word[31] == $past(regWrData[31]))
    else $error("valid flag not staged");
  AST_PRIO_MSTI_FID: assert property (
    wrEntry0 |=> entry0Word[26:24] == $past(regWrData[26:24])
    && entry0Word[14:12] == $past(regWrData[14:12])
    && entry0Word[6:0] == $past(regWrData[6:0]))
    else $error("entry fields not staged");
  AST_ENTRY0_RESV: assert property (
    regRdStb && regAddr == `VLQM_ADDR_ENTRY0
    |=> regRdData[30:28] == 3'h0 && regRdData[23:15] == 9'h000
    && regRdData[11:7] == 5'h00)
    else $error("reserved entry bits not zero");
  AST_UNTAG_BITS: assert property (
    wrEntry1 |=> entry1Word[6] == $past(regWrData[6])
    && entry1Word[3:0] == $past(regWrData[3:0])
    && entry1Word[31:7] == 25'h000_0000 && entry1Word[5:4] == 2'h0)
    else $error("untag bits not staged");
  AST_INDEX_HELD: assert property (
    busy ##1 busy |-> $stable(tblReq.index) && $stable(tblReq.action))
    else $error("index moved during a table action");
  AST_READ_LOADS: assert property (
    busy && tblRsp.done && actionReg == VLQM_ACT_READ
    |=> entry0Word == packEntry0($past(tblRsp.entry))
    && entry1Word == packEntry1($past(tblRsp.entry)))
    else $error("table read result not staged");
  AST_QCTRL_UPPER: assert property (
    regRdStb && regAddr == `VLQM_ADDR_QCTRL |=> regRdData[31:8] == 24'h00_0000)
    else $error("queue control upper bits not zero");

  // ========================================================================
  // Register port checks; the read word is gone one cycle after its strobe
  AST_RD_IDLE_ZERO: assert property (
    !regRdStb |=> regRdData == 32'h0000_0000)
    else $error("read data stood past its cycle");
  AST_QCTRL_STORE: assert property (
    wrQctrl |=> qctrlWord == $past(regWrData[7:0]))
    else $error("queue control word not stored");
  AST_DISCARD_STORE: assert property (
    wrQctrl |=> discardReg == $past(regWrData[1]))
    else $error("discard bit not stored");
  AST_ENTRY1_RESV: assert property (
    regRdStb && regAddr == `VLQM_ADDR_ENTRY1
    |=> regRdData[31:7] == 25'h000_0000 && regRdData[5:4] == 2'h0)
    else $error("reserved untag bits not zero");
  AST_VIDX_RESV: assert property (
    regRdStb && regAddr == `VLQM_ADDR_VIDX
    |=> regRdData[31:12] == 20'h0_0000)
    else $error("reserved index bits not zero");
  AST_ACTL_RESV: assert property (
    regRdStb && regAddr == `VLQM_ADDR_ACTL
    |=> regRdData[31:8] == 24'h00_0000 && regRdData[6:2] == 5'h00)
    else $error("reserved control bits not zero");

  // Table side checks; staging must not move under a running action
  AST_BUSY_STAGE_HELD: assert property (
    busy && !tblRsp.done |=> $stable(entryReg) && $stable(idxReg))
    else $error("staging changed during a table action");
  AST_WRITE_KEEPS_STAGE: assert property (
    busy && tblRsp.done && actionReg != VLQM_ACT_READ |=> $stable(entryReg))
    else $error("write or clear altered the staging entry");
  AST_REQ_ONLY_BUSY: assert property (
    tblReq.req |-> busy)
    else $error("table request outside an action");

endmodule

/* tb/vlqm_regs_tb.sv */
`timescale 1ns/100ps
`include "vlqm_consts.svh"

module vlqm_regs_tb;
  import vlqm_pkg::*;

  // ==========================================================================
  // Signals around the bank
  logic          core_clk;
  logic          arst_n;
  logic [15:0]   regAddr;
  logic [31:0]   regWrData;
  logic          regWrStb;
  logic          regRdStb;
  logic [31:0]   regRdData;
  vlqm_tbl_req_t tblReq;
  vlqm_tbl_rsp_t tblRsp;
  logic          tableBusy;
  vlqm_frame_t   frameIn;
  vlqm_verdict_t verdictOut;
  int            fail_count;
  int            cmp_count;
  logic [31:0]   rdVal;

  vlqm_regs dut_u (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .regAddr    (regAddr),
    .regWrData  (regWrData),
    .regWrStb   (regWrStb),
    .regRdStb   (regRdStb),
    .regRdData  (regRdData),
    .tblReq     (tblReq),
    .tblRsp     (tblRsp),
    .tableBusy  (tableBusy),
    .frameIn    (frameIn),
    .verdictOut (verdictOut)
  );

  // 250 MHz clock
  always #2 core_clk = ~core_clk;

  // ==========================================================================
  // Shared helpers
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkBit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Each access opens on its own edge, so strobes never get two drives
  task automatic wr(input logic [15:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    regAddr   <= addr;
    regWrData <= data;
    regWrStb  <= 1'b1;
    @(posedge core_clk);
    regWrStb  <= 1'b0;
  endtask

  task automatic rdChk(input logic [15:0] addr, input logic [31:0] exp);
    @(posedge core_clk);
    regAddr  <= addr;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 rdVal = regRdData;
    chk($sformatf("reg %h", addr), exp, rdVal);
  endtask

  task automatic startAction(input logic [1:0] act);
    wr(`VLQM_ADDR_ACTL, {24'h00_0000, 1'b1, 5'h00, act});
    #1;
    chkBit("req pulse", 1'b1, tblReq.req);          // Start launches
    chkBit("busy", 1'b1, tableBusy);                 // Start bit held
    chk("action", 32'(act), 32'(tblReq.action));     // Action code
    @(posedge core_clk);
    #1 chkBit("req one cycle", 1'b0, tblReq.req);   // Single pulse
  endtask

  // Table answers; the data lines then show junk, as a real memory might
  task automatic finishAction(input vlqm_entry_t ent);
    @(posedge core_clk);
    tblRsp <= '{done: 1'b1, entry: ent};
    @(posedge core_clk);
    tblRsp <= '{done: 1'b0, entry: ~ent};
    #1 chkBit("busy after done", 1'b0, tableBusy);  // Self-clear
  endtask

  task automatic frm(input logic [1:0] pr, input logic useEntry,
                     input logic [4:0] entP, input logic [4:0] othP,
                     input logic [4:0] memP, input logic mir,
                     input logic mirOth, input logic expHigh,
                     input logic [4:0] expPorts, input logic expDrop);
    @(posedge core_clk);
    frameIn <= '{valid: 1'b1, prio: pr, entryFwdOpt: useEntry,
                 entryPorts: entP, otherPorts: othP, memberPorts: memP,
                 mirrorActive: mir, mirrorToOther: mirOth};
    @(posedge core_clk);
    frameIn.valid <= 1'b0;
    #1;
    chkBit("verdict valid", 1'b1, verdictOut.valid);
    chkBit("high queue", expHigh, verdictOut.highQueue);       // Map
    chk("ports", 32'(expPorts), 32'(verdictOut.ports));        // Set
    chkBit("drop", expDrop, verdictOut.drop);                  // Drop
  endtask

  // Expected queue choice worked out from the map code table
  function automatic logic qHigh(input logic [1:0] code,
                                 input logic [1:0] p);
    case (code)
      2'b00:   return p == 2'b11;
      2'b11:   return p != 2'b00;
      default: return p[1];
    endcase
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic testResetValues();
    rdChk(`VLQM_ADDR_QCTRL, 32'h0000_0082);   // Map 10, discard on
    @(posedge core_clk);
    #1 chk("read data gone", 32'h0000_0000, regRdData); // One cycle
    rdChk(`VLQM_ADDR_ENTRY0, 32'h0000_0000);  // Entry invalid
    rdChk(`VLQM_ADDR_ENTRY1, 32'h0000_0000);  // No untag
    rdChk(`VLQM_ADDR_VIDX, 32'h0000_0000);    // Index zero
    rdChk(`VLQM_ADDR_ACTL, 32'h0000_0000);    // Idle
    rdChk(16'h0398, 32'h0000_0000);           // Unmapped
  endtask

  task automatic testFields();
    wr(`VLQM_ADDR_QCTRL, 32'hFFFF_FFFF);
    rdChk(`VLQM_ADDR_QCTRL, 32'h0000_00FF);   // Upper bits zero
    wr(`VLQM_ADDR_QCTRL, 32'h0000_0082);
    wr(`VLQM_ADDR_ENTRY0, 32'hFFFF_FFFF);
    rdChk(`VLQM_ADDR_ENTRY0, 32'h8F00_707F);  // Fields only
    wr(`VLQM_ADDR_ENTRY1, 32'hFFFF_FFFF);
    rdChk(`VLQM_ADDR_ENTRY1, 32'h0000_004F);  // Untag 3:0 and 6
    wr(`VLQM_ADDR_VIDX, 32'hFFFF_FABC);
    rdChk(`VLQM_ADDR_VIDX, 32'h0000_0ABC);    // Twelve bits
    wr(16'h0398, 32'hFFFF_FFFF);
    rdChk(16'h0398, 32'h0000_0000);           // Unmapped write lost
  endtask

  task automatic testWriteAction();
    startAction(VLQM_ACT_WRITE);                      // Write
    chk("index", 32'h0000_0ABC, 32'(tblReq.index));   // Addressed
    chk("entry", 32'h000F_FFFF, 32'(tblReq.entry));   // Staged out
    wr(`VLQM_ADDR_ENTRY0, 32'h0000_0000);
    rdChk(`VLQM_ADDR_ACTL, 32'h0000_0081);    // Busy readback
    chk("index held", 32'h0000_0ABC, 32'(tblReq.index));  // Stable
    finishAction('0);
    rdChk(`VLQM_ADDR_ENTRY0, 32'h8F00_707F);  // Busy write lost
  endtask

  task automatic testReadAction();
    startAction(VLQM_ACT_READ);               // Read
    finishAction(20'hA_BAB6);
    rdChk(`VLQM_ADDR_ENTRY0, 32'h8500_3055);  // Loaded
    rdChk(`VLQM_ADDR_ENTRY1, 32'h0000_0046);  // Port 5 on bit 6
    rdChk(`VLQM_ADDR_ACTL, 32'h0000_0002);    // Start cleared
  endtask

  task automatic testClearAndNop();
    startAction(VLQM_ACT_CLEAR);              // Clear all
    finishAction('1);
    rdChk(`VLQM_ADDR_ENTRY0, 32'h8500_3055);  // Staging kept
    wr(`VLQM_ADDR_ACTL, 32'h0000_0080);
    #1;
    chkBit("nop busy", 1'b0, tableBusy);      // No operation
    chkBit("nop req", 1'b0, tblReq.req);      // No operation
    rdChk(`VLQM_ADDR_ACTL, 32'h0000_0000);    // Start reads zero
  endtask

  task automatic testQueueMap();
    logic [1:0] c;
    logic [1:0] p;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(`VLQM_ADDR_QCTRL, {24'h00_0000, c, 6'h02});
      for (int j = 0; j < 4; j++) begin
        p = 2'(j);
        frm(p, 1'b1, 5'h02, 5'h04, 5'h03, 1'b0, 1'b0, qHigh(c, p),
            5'h02, 1'b0);                                      // Codes
      end
    end
    wr(`VLQM_ADDR_QCTRL, 32'h0000_0082);
  endtask

  task automatic testMembership();
    frm(2'h0, 1'b1, 5'h02, 5'h1F, 5'h03, 1'b0, 1'b0, 1'b0, 5'h02, 1'b0);
    // Entry map chosen, inside membership
    frm(2'h0, 1'b0, 5'h1F, 5'h04, 5'h03, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0);
    // Other map chosen, single target confined
    frm(2'h0, 1'b0, 5'h1F, 5'h0E, 5'h06, 1'b1, 1'b1, 1'b0, 5'h06, 1'b0);
    // Multi target confined, mirroring no matter
    wr(`VLQM_ADDR_QCTRL, 32'h0000_0080);
    frm(2'h0, 1'b0, 5'h1F, 5'h04, 5'h03, 1'b0, 1'b0, 1'b0, 5'h04, 1'b0);
    // Single target unconfined
    frm(2'h0, 1'b1, 5'h08, 5'h01, 5'h03, 1'b1, 1'b1, 1'b0, 5'h00, 1'b1);
    // Mirrored single target drops
    frm(2'h0, 1'b1, 5'h08, 5'h01, 5'h03, 1'b1, 1'b0, 1'b0, 5'h08, 1'b0);
    // Mirroring elsewhere only keeps it
    frm(2'h0, 1'b0, 5'h1F, 5'h06, 5'h02, 1'b1, 1'b1, 1'b0, 5'h02, 1'b0);
    // Multi target still confined
  endtask

  // ==========================================================================
  // Verdict and run control
  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Run needs well under 1000 cycles
  initial begin
    #20000;
    fail_count++;
    conclude();
  end

  initial begin
    core_clk   = 1'b0;
    arst_n     = 1'b0;
    regAddr    = 16'h0000;
    regWrData  = 32'h0000_0000;
    regWrStb   = 1'b0;
    regRdStb   = 1'b0;
    tblRsp     = '0;
    frameIn    = '0;
    fail_count = 0;
    cmp_count  = 0;
    repeat (8) @(posedge core_clk);
    chkBit("busy in reset", 1'b0, tableBusy);
    arst_n <= 1'b1;
    testResetValues();
    testFields();
    testWriteAction();
    testReadAction();
    testClearAndNop();
    testQueueMap();
    testMembership();
    conclude();
  end

endmodule
